// file: ncofp_pkg.sv
package ncofp_pkg;
  // Presets per down-converter and derived widths.
  localparam int          NUM_PRESETS      = 4;
  localparam int          PRESET_W         = 2;
  // Register map: frequency words, phase offsets, then control and status.
  localparam logic [11:0] FREQ_A_BASE      = 12'h000;
  localparam logic [11:0] FREQ_B_BASE      = 12'h010;
  localparam logic [11:0] PHASE_A_BASE     = 12'h020;
  localparam logic [11:0] PHASE_B_BASE     = 12'h030;
  localparam logic [11:0] CTRL_ADDR        = 12'h040;
  localparam logic [11:0] STATUS_ADDR      = 12'h044;
  localparam logic [11:0] ACC_A_ADDR       = 12'h048;
  localparam logic [11:0] ACC_B_ADDR       = 12'h04c;
  // Reset values.
  localparam logic [31:0] FREQ_RESET       = 32'hc0000000;
  localparam logic [15:0] PHASE_RESET      = 16'h0000;
  // Control field positions.
  localparam int          CTRL_SEL_A_LSB   = 0;
  localparam int          CTRL_SEL_B_LSB   = 2;
  localparam int          CTRL_ILA_BIT     = 4;
  localparam logic [31:0] CTRL_RESET       = 32'h00000010;
  // Status field positions.
  localparam int          STAT_NONDET_BIT  = 0;
  localparam int          STAT_LINK_BIT    = 1;
  // Link-state machine.
  typedef enum logic [2:0] {
    NCOFP_IDLE = 3'b001,
    NCOFP_RUN  = 3'b010,
    NCOFP_DIRTY = 3'b100
  } ncofp_link_e;
endpackage

// file: ncofp_mem.sv
`timescale 1ns/1ps
// Small word store for the presets; read data come out of a register.
module ncofp_mem
  import ncofp_pkg::*;
#(
  parameter int             DEPTH = 8,
  parameter int             AW    = 3,
  parameter int             W     = 32,
  parameter logic [31:0]    RST   = 32'h00000000
) (
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Registered read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata,
  // Full contents, for the datapath selectors.
  output logic      [W-1:0]  words [DEPTH]
);
  // Storage resets so that every preset has a defined power-up value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= RST[W-1:0];
      end
    end else if (we) begin
      words[waddr] <= wdata;
    end
  end

  // Read data registered one cycle after the address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= words[raddr];
    end
  end
endmodule

// file: ncofp_top.sv
// Operation
// R1 - 32-bit RW frequency word, resets 0xc0000000
// R2 - Frequency rewrite while link runs: phase nondeterministic
// R3 - Host reinitializes link for deterministic phase
// R4 - Words work signed or unsigned alike
// R5 - Phase offset placed in upper half, added
// R6 - 16-bit RW phase offset, resets zero
// R7 - Lane-align sync initializes phase at ILA LMFC
// R8 - Accumulator adds frequency each cycle, wraps 2^32
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ncofp_top
  import ncofp_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link status from the serial interface.
  input  wire logic        link_running,
  input  wire logic        ila_lmfc_edge,
  // Oscillator phase outputs.
  output logic      [31:0] nco_phase_a,
  output logic      [31:0] nco_phase_b
);
  localparam int NW = 2 * NUM_PRESETS;

  // APB decode. Writes take effect in the access cycle; reads need one wait state.
  logic        acc_phase;
  logic        wr_en;
  logic        rd_wait_reg;
  logic [11:0] addr_word;
  logic        hit_freq;
  logic        hit_phase;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_acc;
  logic        hit_any;
  logic [2:0]  mem_idx;

  assign acc_phase = psel && penable;
  assign addr_word = {paddr[11:2], 2'b00};
  assign hit_freq  = (addr_word < PHASE_A_BASE);
  assign hit_phase = (addr_word >= PHASE_A_BASE) && (addr_word < CTRL_ADDR);
  assign hit_ctrl  = (addr_word == CTRL_ADDR);
  assign hit_stat  = (addr_word == STATUS_ADDR);
  assign hit_acc   = (addr_word == ACC_A_ADDR) || (addr_word == ACC_B_ADDR);
  assign hit_any   = hit_freq || hit_phase || hit_ctrl || hit_stat || hit_acc;
  assign mem_idx   = {paddr[4], paddr[3:2]};
  assign wr_en     = acc_phase && pwrite && hit_any && (paddr[1:0] == 2'b00);
  assign pready    = pwrite ? acc_phase : (acc_phase && rd_wait_reg);
  assign pslverr   = pready && !(hit_any && (paddr[1:0] == 2'b00));

  // Read wait flag: set in the first access cycle of a read, cleared on completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_reg <= 1'b0;
    end else if (acc_phase && !pwrite && !rd_wait_reg) begin
      rd_wait_reg <= 1'b1;
    end else begin
      rd_wait_reg <= 1'b0;
    end
  end

  // Preset stores: A presets at indices 0..3, B presets at 4..7.
  logic [31:0] freq_words  [NW];
  logic [15:0] phase_words [NW];
  logic [31:0] freq_rdata;
  logic [15:0] phase_rdata;

  ncofp_mem #(.DEPTH(NW), .AW(3), .W(32), .RST(FREQ_RESET)) u_freq (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_en && hit_freq), // R1
    .waddr   (mem_idx),
    .wdata   (pwdata),
    .raddr   (mem_idx),
    .rdata   (freq_rdata),
    .words   (freq_words)
  );

  ncofp_mem #(.DEPTH(NW), .AW(3), .W(16), .RST({16'h0000, PHASE_RESET})) u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_en && hit_phase), // R6
    .waddr   (mem_idx),
    .wdata   (pwdata[15:0]),
    .raddr   (mem_idx),
    .rdata   (phase_rdata),
    .words   (phase_words)
  );

  // Control register: preset selects and the lane-align sync enable.
  logic [31:0] ctrl_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= {27'h0, pwdata[4:0]};
    end
  end

  logic [PRESET_W-1:0] sel_a;
  logic [PRESET_W-1:0] sel_b;
  logic                osc_init_on_lane_align;
  assign sel_a = ctrl_reg[CTRL_SEL_A_LSB +: PRESET_W];
  assign sel_b = ctrl_reg[CTRL_SEL_B_LSB +: PRESET_W];
  assign osc_init_on_lane_align = ctrl_reg[CTRL_ILA_BIT];

  // Link inputs come from another domain and pass two flip-flops.
  logic [1:0] run_sync;
  logic [1:0] ila_sync;
  logic       ila_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_sync <= 2'b00;
      ila_sync <= 2'b00;
      ila_prev <= 1'b0;
    end else begin
      run_sync <= {run_sync[0], link_running};
      ila_sync <= {ila_sync[0], ila_lmfc_edge};
      ila_prev <= ila_sync[1];
    end
  end

  logic link_up;
  logic ila_rise;
  assign link_up  = run_sync[1];
  assign ila_rise = ila_sync[1] && !ila_prev;

  // Link-state tracking: a frequency write while running leaves the phase unknown
  // until a lane-align init restarts it or the link drops.
  ncofp_link_e link_state;
  logic        freq_write;
  logic        phase_init;
  assign freq_write = wr_en && hit_freq;
  assign phase_init = ila_rise && osc_init_on_lane_align; // R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state <= NCOFP_IDLE;
    end else begin
      case (link_state)
        NCOFP_IDLE: begin
          // A write that lands as the link comes up already counts as a rewrite.
          if (link_up && freq_write) begin
            link_state <= NCOFP_DIRTY; // R2
          end else if (link_up) begin
            link_state <= NCOFP_RUN;
          end
        end
        NCOFP_RUN: begin
          if (!link_up) begin
            link_state <= NCOFP_IDLE;
          end else if (freq_write) begin
            link_state <= NCOFP_DIRTY; // R2
          end
        end
        NCOFP_DIRTY: begin
          // A rewrite in the init cycle wins: its word arrives after the init.
          if (phase_init && !freq_write) begin
            link_state <= NCOFP_RUN; // R3
          end else if (!link_up) begin
            link_state <= NCOFP_IDLE;
          end
        end
        default: begin
          link_state <= NCOFP_IDLE;
        end
      endcase
    end
  end

  // Accumulators: plain modulo-2^32 sums serve signed and unsigned words alike.
  logic [31:0] acc_a_reg;
  logic [31:0] acc_b_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_reg <= 32'h00000000;
      acc_b_reg <= 32'h00000000;
    end else if (phase_init) begin
      acc_a_reg <= 32'h00000000; // R7
      acc_b_reg <= 32'h00000000;
    end else begin
      acc_a_reg <= acc_a_reg + freq_words[{1'b0, sel_a}]; // R8 R4
      acc_b_reg <= acc_b_reg + freq_words[{1'b1, sel_b}];
    end
  end

  // Offset is MSB-justified and added after the accumulator.
  function automatic logic [31:0] justify(input logic [15:0] ph);
    justify = {ph, 16'h0000};
  endfunction

  // Output phases are registered so the datapath sees clean data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_phase_a <= 32'h00000000;
      nco_phase_b <= 32'h00000000;
    end else begin
      nco_phase_a <= acc_a_reg + justify(phase_words[{1'b0, sel_a}]); // R5 R4
      nco_phase_b <= acc_b_reg + justify(phase_words[{1'b1, sel_b}]);
    end
  end

  // Read mux, captured at the end of the first access cycle, when the store's
  // registered data is ready, so that prdata already stands while pready is high.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_freq) begin
      rd_mux = freq_rdata;
    end else if (hit_phase) begin
      rd_mux = {16'h0000, phase_rdata};
    end else if (hit_ctrl) begin
      rd_mux = ctrl_reg;
    end else if (hit_stat) begin
      rd_mux = {30'h0, link_up, link_state == NCOFP_DIRTY};
    end else if (addr_word == ACC_A_ADDR) begin
      rd_mux = acc_a_reg;
    end else if (addr_word == ACC_B_ADDR) begin
      rd_mux = acc_b_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (acc_phase && !pwrite && !rd_wait_reg) begin
      prdata <= rd_mux;
    end
  end

  // Assertions.
  sequence s_freq_wr_running;
    (link_state == NCOFP_RUN) && link_up && freq_write;
  endsequence

  a_dirty_on_write: assert property (@(posedge pclk) disable iff (!presetn) // R2
    s_freq_wr_running |=> (link_state == NCOFP_DIRTY))
    else $error("frequency write while running did not flag phase");

  a_ila_clears: assert property (@(posedge pclk) disable iff (!presetn) // R7
    phase_init |=> (acc_a_reg == 32'h00000000) && (acc_b_reg == 32'h00000000))
    else $error("lane-align edge did not initialise the accumulators");

  a_acc_steps: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !phase_init && !$past(freq_write) |=>
      acc_a_reg == $past(acc_a_reg) + $past(freq_words[{1'b0, sel_a}]))
    else $error("accumulator A did not step by its frequency word");

  a_offset_add: assert property (@(posedge pclk) disable iff (!presetn) // R5
    1'b1 |=> nco_phase_b == $past(acc_b_reg) + {$past(phase_words[{1'b1, sel_b}]), 16'h0000})
    else $error("phase offset not added in upper half");

  a_freq_store: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (wr_en && hit_freq) |=> freq_words[$past(mem_idx)] == $past(pwdata))
    else $error("frequency word write not stored");

  a_phase_store: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && hit_phase) |=> phase_words[$past(mem_idx)] == $past(pwdata[15:0]))
    else $error("phase offset write not stored");

  a_read_wait: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (acc_phase && !pwrite && !rd_wait_reg) |-> !pready ##1 pready)
    else $error("read did not complete after one wait state");

  a_signed_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (!phase_init && freq_words[{1'b1, sel_b}] == 32'hffffffff && !freq_write) |=>
      acc_b_reg == $past(acc_b_reg) - 32'h00000001)
    else $error("all-ones word did not step back by one");

  // A rewrite on a running link keeps the phase flagged until a lane-align init or a link drop.
  sequence s_dirty_lane_init;
    (link_state == NCOFP_DIRTY) && phase_init && !freq_write;
  endsequence

  a_init_restores: assert property (@(posedge pclk) disable iff (!presetn) // R7
    s_dirty_lane_init |=> (link_state == NCOFP_RUN))
    else $error("lane-align init did not restore deterministic phase");

  a_dirty_holds: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (link_state == NCOFP_DIRTY) && link_up && !phase_init |=> (link_state == NCOFP_DIRTY))
    else $error("phase flag dropped without lane-align init");

  a_write_no_wait: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (acc_phase && pwrite) |-> pready)
    else $error("write was not answered in its first access cycle");

  a_read_data: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (pready && !pwrite && hit_freq && !pslverr) |-> (prdata == freq_words[mem_idx]))
    else $error("frequency word read data not standing with ready");

  a_refused_keeps: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (pready && pslverr) |=> $stable(ctrl_reg))
    else $error("refused access changed the control register");
endmodule

// file: nco_freq_phase_presets_test.sv
`timescale 1ns/1ps
module nco_freq_phase_presets_test
  import ncofp_pkg::*;
;
  // Clock, reset and bus.
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Link status and oscillator outputs.
  logic        link_running;
  logic        ila_lmfc_edge;
  logic [31:0] nco_phase_a;
  logic [31:0] nco_phase_b;
  int          num_errors;
  int          n_compared;

  ncofp_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_running(link_running),
    .ila_lmfc_edge(ila_lmfc_edge), .nco_phase_a(nco_phase_a), .nco_phase_b(nco_phase_b)
  );

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; the wait for the answer is bounded so a dead slave cannot hang us.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // Answer and read data are looked at mid-cycle, where they have settled; the
    // transfer completes at the rising edge that follows, and only then is it released.
    if (pready !== 1'b1) begin
      chk({31'h0, pready}, 32'h1);
      wrap_up();
    end else begin
      err = pslverr;
      rd  = prdata;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0);
    chk(r, exp);
  endtask

  // Every preset word and offset of both converters comes up at its reset value.
  task automatic test_reset();
    for (int p = 0; p < NUM_PRESETS; p++) begin
      rd_chk(FREQ_A_BASE + 12'(4 * p), FREQ_RESET);
      rd_chk(FREQ_B_BASE + 12'(4 * p), FREQ_RESET);
      rd_chk(PHASE_A_BASE + 12'(4 * p), 32'h0);
      rd_chk(PHASE_B_BASE + 12'(4 * p), 32'h0);
    end
    rd_chk(CTRL_ADDR, CTRL_RESET);
    $display("test reset values done");
  endtask

  // Single writes land in the right preset and one neighbouring word stays put.
  task automatic test_rw();
    wr(FREQ_A_BASE + 12'h00c, 32'hdeadbeef);
    rd_chk(FREQ_A_BASE + 12'h00c, 32'hdeadbeef);
    rd_chk(FREQ_A_BASE + 12'h008, FREQ_RESET);
    wr(PHASE_B_BASE + 12'h008, 32'habcd5678);
    rd_chk(PHASE_B_BASE + 12'h008, 32'h00005678);
    $display("test read write done");
  endtask

  // Unmapped and unaligned places answer with an error and change nothing.
  task automatic test_refused();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h050, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, FREQ_A_BASE + 12'h001, 32'h12345678, r, e);
    chk({31'h0, e}, 32'h1);
    rd_chk(FREQ_A_BASE, FREQ_RESET);
    $display("test refused access done");
  endtask

  // Phase steps by the selected word each cycle, signed steps wrap like unsigned ones.
  task automatic test_accum();
    logic [31:0] p0;
    logic [31:0] steps [2] = '{32'h00000005, 32'hfffffffb};
    wr(CTRL_ADDR, 32'h00000012);
    for (int i = 0; i < 2; i++) begin
      wr(FREQ_A_BASE + 12'h008, steps[i]);
      repeat (3) @(negedge pclk);
      p0 = nco_phase_a;
      @(negedge pclk);
      chk(nco_phase_a - p0, steps[i]);
    end
    p0 = nco_phase_b;
    @(negedge pclk);
    chk(nco_phase_b - p0, FREQ_RESET);
    wr(FREQ_B_BASE, 32'hffffffff);
    repeat (3) @(negedge pclk);
    p0 = nco_phase_b;
    @(negedge pclk);
    chk(nco_phase_b - p0, 32'hffffffff);
    $display("test accumulator done");
  endtask

  // With a zero step, only the offset moves the output, placed in the upper half.
  task automatic test_offset();
    logic [31:0] b0;
    wr(FREQ_B_BASE, 32'h0);
    repeat (3) @(negedge pclk);
    b0 = nco_phase_b;
    wr(PHASE_B_BASE, 32'h00001234);
    repeat (3) @(negedge pclk);
    chk(nco_phase_b - b0, 32'h12340000);
    wr(PHASE_B_BASE, 32'h0000ffff);
    repeat (3) @(negedge pclk);
    chk(nco_phase_b - b0, 32'hffff0000);
    $display("test phase offset done");
  endtask

  // A rewrite on a running link flags the phase; a lane-align edge restarts it.
  task automatic test_link();
    wr(CTRL_ADDR, 32'h00000010);
    wr(FREQ_A_BASE, 32'h0);
    rd_chk(STATUS_ADDR, 32'h0);
    @(posedge pclk);
    link_running <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(FREQ_A_BASE + 12'h004, 32'h00000007);
    rd_chk(STATUS_ADDR, 32'h3);
    ila_lmfc_edge <= 1'b1;
    repeat (4) @(posedge pclk);
    ila_lmfc_edge <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(ACC_A_ADDR, 32'h0);
    @(negedge pclk);
    chk(nco_phase_a, 32'h0);
    rd_chk(STATUS_ADDR, 32'h2);
    // With lane-align init off, the edge must leave the flag set; a link drop clears it.
    wr(CTRL_ADDR, 32'h00000000);
    wr(FREQ_A_BASE + 12'h004, 32'h00000009);
    ila_lmfc_edge <= 1'b1;
    repeat (4) @(posedge pclk);
    ila_lmfc_edge <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(STATUS_ADDR, 32'h3);
    link_running <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(STATUS_ADDR, 32'h0);
    $display("test link and lane align done");
  endtask

  // Reset is held for eight cycles, then the scenarios run in turn.
  initial begin
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 12'h000;
    pwdata        = 32'h0;
    link_running  = 1'b0;
    ila_lmfc_edge = 1'b0;
    num_errors    = 0;
    n_compared    = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_rw();
    test_refused();
    test_accum();
    test_offset();
    test_link();
    wrap_up();
  end
endmodule
